//--- logic/prcb_pkg.sv
// shared constants and types of the power resource configuration bank
package prcb_pkg;

    localparam int          PRCB_NUM_RES      = 5;
    localparam logic [6:0]  PRCB_DEVICE_ADDR  = 7'h4b;
    localparam logic [3:0]  PRCB_BYTE_BITS    = 4'h8;

    // resource order: power-on reset, clock enable, system enable, fast clock, slow clock
    localparam logic [7:0]  PRCB_RESET_OUT_GROUP   = 8'hdd;
    localparam logic [7:0]  PRCB_RESET_OUT_CLASS   = 8'hde;
    localparam logic [7:0]  PRCB_RESET_OUT_REMAP   = 8'hdf;
    localparam logic [7:0]  PRCB_CLOCK_EN_GROUP    = 8'he0;
    localparam logic [7:0]  PRCB_CLOCK_EN_CLASS    = 8'he1;
    localparam logic [7:0]  PRCB_CLOCK_EN_REMAP    = 8'he2;
    localparam logic [7:0]  PRCB_SYSTEM_EN_GROUP   = 8'he3;
    localparam logic [7:0]  PRCB_SYSTEM_EN_CLASS   = 8'he4;
    localparam logic [7:0]  PRCB_SYSTEM_EN_REMAP   = 8'he5;
    localparam logic [7:0]  PRCB_FAST_CLK_GROUP    = 8'he6;
    localparam logic [7:0]  PRCB_FAST_CLK_CLASS    = 8'he7;
    localparam logic [7:0]  PRCB_FAST_CLK_REMAP    = 8'he8;
    localparam logic [7:0]  PRCB_SLOW_CLK_GROUP    = 8'he9;
    localparam logic [7:0]  PRCB_SLOW_CLK_CLASS    = 8'hea;
    localparam logic [7:0]  PRCB_SLOW_CLK_REMAP    = 8'heb;

    localparam logic [39:0] PRCB_GROUP_OFFSETS = {PRCB_SLOW_CLK_GROUP, PRCB_FAST_CLK_GROUP,
        PRCB_SYSTEM_EN_GROUP, PRCB_CLOCK_EN_GROUP, PRCB_RESET_OUT_GROUP};
    localparam logic [39:0] PRCB_CLASS_OFFSETS = {PRCB_SLOW_CLK_CLASS, PRCB_FAST_CLK_CLASS,
        PRCB_SYSTEM_EN_CLASS, PRCB_CLOCK_EN_CLASS, PRCB_RESET_OUT_CLASS};
    localparam logic [39:0] PRCB_REMAP_OFFSETS = {PRCB_SLOW_CLK_REMAP, PRCB_FAST_CLK_REMAP,
        PRCB_SYSTEM_EN_REMAP, PRCB_CLOCK_EN_REMAP, PRCB_RESET_OUT_REMAP};

    // field layout
    localparam int          PRCB_GROUP_MSB    = 7;
    localparam int          PRCB_GROUP_LSB    = 5;
    localparam int          PRCB_WARM_BIT     = 4;
    localparam int          PRCB_SEC_MSB      = 4;
    localparam int          PRCB_SEC_LSB      = 3;
    localparam int          PRCB_PRI_MSB      = 2;
    localparam int          PRCB_OFF_MSB      = 7;
    localparam int          PRCB_OFF_LSB      = 4;
    localparam int          PRCB_SLEEP_MSB    = 3;

    // reset values
    localparam logic [2:0]  PRCB_GROUP_ALL    = 3'h7;
    localparam logic [1:0]  PRCB_SEC_RESET    = 2'h0;
    localparam logic [3:0]  PRCB_OFF_RESET    = 4'h0;
    localparam logic [3:0]  PRCB_SLEEP_RESET  = 4'h8;
    localparam logic [3:0]  PRCB_STATE_RESET  = 4'h0;
    localparam logic [2:0]  PRCB_RESERVED_RD  = 3'h0;
    localparam logic [7:0]  PRCB_UNMAPPED_RD  = 8'h00;
    localparam logic [14:0] PRCB_PRI_RESETS   = {3'h0, 3'h0, 3'h6, 3'h3, 3'h0};

    // system condition from the sequencer
    localparam logic [1:0]  PRCB_COND_ACTIVE  = 2'h0;
    localparam logic [1:0]  PRCB_COND_SLEEP   = 2'h1;
    localparam logic [1:0]  PRCB_COND_OFF     = 2'h2;

    typedef enum logic [3:0] {
        PRCB_IDLE, PRCB_ADDR, PRCB_ADDR_ACK, PRCB_PTR, PRCB_PTR_ACK,
        PRCB_WDATA, PRCB_WDATA_ACK, PRCB_RDATA, PRCB_RDATA_ACK
    } prcb_i2c_state_type;

endpackage : prcb_pkg

//--- logic/prcb_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module prcb_sync #(
    parameter logic IDLE_LEVEL = 1'b1
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic pin,
    output logic      level
);
    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1 <= IDLE_LEVEL;
            stage2 <= IDLE_LEVEL;
            stage3 <= IDLE_LEVEL;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // only stages two and three vote; stage one may be metastable
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            level <= IDLE_LEVEL;
        end else if (stage2 == stage3) begin
            level <= stage3;
        end
    end
endmodule : prcb_sync

//--- logic/prcb_resource.sv
// one resource: group, class and remap registers
`timescale 1ns/1ps
module prcb_resource #(
    parameter logic [2:0] PRI_RESET = 3'h0
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       wr_group,
    input  wire logic       wr_class,
    input  wire logic       wr_remap,
    input  wire logic [7:0] wr_data,
    input  wire logic       warm_enter,
    input  wire logic [3:0] present_state,
    input  wire logic [1:0] sys_cond,
    output logic      [7:0] group_rd,
    output logic      [7:0] class_rd,
    output logic      [7:0] remap_rd,
    output logic      [2:0] group_membership,
    output logic      [1:0] secondary_class,
    output logic      [2:0] primary_class,
    output logic      [3:0] target_state,
    output logic            vsel_restore
);
    logic       warm_cfg;
    logic [3:0] state;
    logic [3:0] off_state;
    logic [3:0] sleep_state;

    // warm-reset force beats a host write in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            group_membership <= prcb_pkg::PRCB_GROUP_ALL;
            warm_cfg         <= 1'b0;
        end else begin
            if (warm_enter && warm_cfg) begin
                group_membership <= prcb_pkg::PRCB_GROUP_ALL;
            end else if (wr_group) begin
                group_membership <= wr_data[prcb_pkg::PRCB_GROUP_MSB:prcb_pkg::PRCB_GROUP_LSB];
            end
            if (wr_group) begin
                warm_cfg <= wr_data[prcb_pkg::PRCB_WARM_BIT];
            end
        end
    end

    // restore pulse on every warm entry, whatever the policy
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vsel_restore <= 1'b0;
        end else begin
            vsel_restore <= warm_enter;
        end
    end

    // state follows the sequencer only; host writes never reach it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= prcb_pkg::PRCB_STATE_RESET;
        end else begin
            state <= present_state;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            secondary_class <= prcb_pkg::PRCB_SEC_RESET;
            primary_class   <= PRI_RESET;
        end else if (wr_class) begin
            secondary_class <= wr_data[prcb_pkg::PRCB_SEC_MSB:prcb_pkg::PRCB_SEC_LSB];
            primary_class   <= wr_data[prcb_pkg::PRCB_PRI_MSB:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            off_state   <= prcb_pkg::PRCB_OFF_RESET;
            sleep_state <= prcb_pkg::PRCB_SLEEP_RESET;
        end else if (wr_remap) begin
            off_state   <= wr_data[prcb_pkg::PRCB_OFF_MSB:prcb_pkg::PRCB_OFF_LSB];
            sleep_state <= wr_data[prcb_pkg::PRCB_SLEEP_MSB:0];
        end
    end

    // remap applies only in sleep or off; otherwise live state passes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            target_state <= prcb_pkg::PRCB_STATE_RESET;
        end else begin
            case (sys_cond)
                prcb_pkg::PRCB_COND_SLEEP: target_state <= sleep_state;
                prcb_pkg::PRCB_COND_OFF:   target_state <= off_state;
                default:                   target_state <= present_state;
            endcase
        end
    end

    assign group_rd = {group_membership, warm_cfg, state};
    assign class_rd = {prcb_pkg::PRCB_RESERVED_RD, secondary_class, primary_class};
    assign remap_rd = {off_state, sleep_state};
endmodule : prcb_resource

//--- logic/prcb_bank.sv
// power resource configuration bank reached over the two-wire serial port
`timescale 1ns/1ps
module prcb_bank #(
    parameter int         NUM_RES     = prcb_pkg::PRCB_NUM_RES,
    parameter logic [6:0] DEVICE_ADDR = prcb_pkg::PRCB_DEVICE_ADDR
) (
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic                 scl,
    input  wire logic                 sda_in,
    output logic                      sda_out,
    output logic                      sda_oe_n,
    input  wire logic [NUM_RES-1:0]   warm_enter,
    input  wire logic [NUM_RES*4-1:0] present_state,
    input  wire logic [1:0]           sys_cond,
    output logic      [NUM_RES*3-1:0] group_membership,
    output logic      [NUM_RES*2-1:0] secondary_class,
    output logic      [NUM_RES*3-1:0] primary_class,
    output logic      [NUM_RES*4-1:0] target_state,
    output logic      [NUM_RES-1:0]   vsel_restore
);
    logic                        scl_s;
    logic                        sda_s;
    logic                        scl_q;
    logic                        sda_q;
    logic                        scl_rise;
    logic                        scl_fall;
    logic                        start_seen;
    logic                        stop_seen;
    prcb_pkg::prcb_i2c_state_type state;
    logic [3:0]                  bit_cnt;
    logic [7:0]                  shift_in;
    logic [7:0]                  shift_out;
    logic [7:0]                  pointer;
    logic                        read_mode;
    logic                        master_ack;
    logic                        wr_strobe;
    logic [7:0]                  wr_addr;
    logic [7:0]                  wr_byte;
    logic [7:0]                  rd_byte;
    logic [NUM_RES*8-1:0]        group_rd;
    logic [NUM_RES*8-1:0]        class_rd;
    logic [NUM_RES*8-1:0]        remap_rd;
    logic [NUM_RES-1:0]          wr_group;
    logic [NUM_RES-1:0]          wr_class;
    logic [NUM_RES-1:0]          wr_remap;

    prcb_sync #(
        .IDLE_LEVEL (1'b1)
    ) u_scl_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .pin    (scl),
        .level  (scl_s)
    );

    prcb_sync #(
        .IDLE_LEVEL (1'b1)
    ) u_sda_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .pin    (sda_in),
        .level  (sda_s)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    assign scl_rise   = scl_s & ~scl_q;
    assign scl_fall   = ~scl_s & scl_q;
    assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_seen  = scl_s & scl_q & ~sda_q & sda_s;

    // bits are sampled on rising clock edges only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_in   <= 8'h00;
            master_ack <= 1'b0;
        end else if (scl_rise) begin
            if (state == prcb_pkg::PRCB_ADDR || state == prcb_pkg::PRCB_PTR
                    || state == prcb_pkg::PRCB_WDATA) begin
                shift_in <= {shift_in[6:0], sda_s};
            end
            if (state == prcb_pkg::PRCB_RDATA_ACK) begin
                master_ack <= ~sda_s;
            end
        end
    end

    // the line is only ever pulled low; a one is sent by releasing it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // protocol sequencer; start and stop override any byte in progress
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state     <= prcb_pkg::PRCB_IDLE;
            bit_cnt   <= 4'h0;
            sda_oe_n  <= 1'b1;
            read_mode <= 1'b0;
            pointer   <= 8'h00;
            shift_out <= 8'h00;
            wr_strobe <= 1'b0;
            wr_addr   <= 8'h00;
            wr_byte   <= 8'h00;
        end else begin
            wr_strobe <= 1'b0;
            if (start_seen) begin
                state    <= prcb_pkg::PRCB_ADDR;
                bit_cnt  <= 4'h0;
                sda_oe_n <= 1'b1;
            end else if (stop_seen) begin
                state    <= prcb_pkg::PRCB_IDLE;
                sda_oe_n <= 1'b1;
            end else if (scl_rise) begin
                if (state == prcb_pkg::PRCB_ADDR || state == prcb_pkg::PRCB_PTR
                        || state == prcb_pkg::PRCB_WDATA) begin
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end else if (scl_fall) begin
                case (state)
                    prcb_pkg::PRCB_ADDR: begin
                        if (bit_cnt == prcb_pkg::PRCB_BYTE_BITS) begin
                            if (shift_in[7:1] == DEVICE_ADDR) begin
                                state     <= prcb_pkg::PRCB_ADDR_ACK;
                                read_mode <= shift_in[0];
                                sda_oe_n  <= 1'b0;
                            end else begin
                                state <= prcb_pkg::PRCB_IDLE;
                            end
                        end
                    end
                    prcb_pkg::PRCB_ADDR_ACK: begin
                        if (read_mode) begin
                            state     <= prcb_pkg::PRCB_RDATA;
                            sda_oe_n  <= rd_byte[7];
                            shift_out <= {rd_byte[6:0], 1'b0};
                            bit_cnt   <= 4'h1;
                            pointer   <= pointer + 8'h01;
                        end else begin
                            state    <= prcb_pkg::PRCB_PTR;
                            sda_oe_n <= 1'b1;
                            bit_cnt  <= 4'h0;
                        end
                    end
                    prcb_pkg::PRCB_PTR: begin
                        if (bit_cnt == prcb_pkg::PRCB_BYTE_BITS) begin
                            state    <= prcb_pkg::PRCB_PTR_ACK;
                            pointer  <= shift_in;
                            sda_oe_n <= 1'b0;
                        end
                    end
                    prcb_pkg::PRCB_PTR_ACK, prcb_pkg::PRCB_WDATA_ACK: begin
                        state    <= prcb_pkg::PRCB_WDATA;
                        sda_oe_n <= 1'b1;
                        bit_cnt  <= 4'h0;
                    end
                    prcb_pkg::PRCB_WDATA: begin
                        if (bit_cnt == prcb_pkg::PRCB_BYTE_BITS) begin
                            state     <= prcb_pkg::PRCB_WDATA_ACK;
                            sda_oe_n  <= 1'b0;
                            wr_strobe <= 1'b1;
                            wr_addr   <= pointer;
                            wr_byte   <= shift_in;
                            pointer   <= pointer + 8'h01;
                        end
                    end
                    prcb_pkg::PRCB_RDATA: begin
                        if (bit_cnt == prcb_pkg::PRCB_BYTE_BITS) begin
                            state    <= prcb_pkg::PRCB_RDATA_ACK;
                            sda_oe_n <= 1'b1;
                        end else begin
                            sda_oe_n  <= shift_out[7];
                            shift_out <= {shift_out[6:0], 1'b0};
                            bit_cnt   <= bit_cnt + 4'h1;
                        end
                    end
                    prcb_pkg::PRCB_RDATA_ACK: begin
                        // a not-acknowledge ends the read burst
                        if (master_ack) begin
                            state     <= prcb_pkg::PRCB_RDATA;
                            sda_oe_n  <= rd_byte[7];
                            shift_out <= {rd_byte[6:0], 1'b0};
                            bit_cnt   <= 4'h1;
                            pointer   <= pointer + 8'h01;
                        end else begin
                            state    <= prcb_pkg::PRCB_IDLE;
                            sda_oe_n <= 1'b1;
                        end
                    end
                    default: begin
                        state    <= prcb_pkg::PRCB_IDLE;
                        sda_oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end

    // write decode; one strobe per byte
    always_comb begin
        for (int i = 0; i < NUM_RES; i++) begin
            wr_group[i] = wr_strobe && (wr_addr == prcb_pkg::PRCB_GROUP_OFFSETS[i*8 +: 8]);
            wr_class[i] = wr_strobe && (wr_addr == prcb_pkg::PRCB_CLASS_OFFSETS[i*8 +: 8]);
            wr_remap[i] = wr_strobe && (wr_addr == prcb_pkg::PRCB_REMAP_OFFSETS[i*8 +: 8]);
        end
    end

    // read mux; unmapped offsets return zero
    always_comb begin
        rd_byte = prcb_pkg::PRCB_UNMAPPED_RD;
        for (int i = 0; i < NUM_RES; i++) begin
            if (pointer == prcb_pkg::PRCB_GROUP_OFFSETS[i*8 +: 8]) begin
                rd_byte = group_rd[i*8 +: 8];
            end
            if (pointer == prcb_pkg::PRCB_CLASS_OFFSETS[i*8 +: 8]) begin
                rd_byte = class_rd[i*8 +: 8];
            end
            if (pointer == prcb_pkg::PRCB_REMAP_OFFSETS[i*8 +: 8]) begin
                rd_byte = remap_rd[i*8 +: 8];
            end
        end
    end

    for (genvar g = 0; g < NUM_RES; g++) begin : g_res
        prcb_resource #(
            .PRI_RESET (prcb_pkg::PRCB_PRI_RESETS[g*3 +: 3])
        ) u_res (
            .clk              (clk),
            .arst_n           (arst_n),
            .wr_group         (wr_group[g]),
            .wr_class         (wr_class[g]),
            .wr_remap         (wr_remap[g]),
            .wr_data          (wr_byte),
            .warm_enter       (warm_enter[g]),
            .present_state    (present_state[g*4 +: 4]),
            .sys_cond         (sys_cond),
            .group_rd         (group_rd[g*8 +: 8]),
            .class_rd         (class_rd[g*8 +: 8]),
            .remap_rd         (remap_rd[g*8 +: 8]),
            .group_membership (group_membership[g*3 +: 3]),
            .secondary_class  (secondary_class[g*2 +: 2]),
            .primary_class    (primary_class[g*3 +: 3]),
            .target_state     (target_state[g*4 +: 4]),
            .vsel_restore     (vsel_restore[g])
        );
    end
endmodule : prcb_bank

//--- tb/prcb_bank_asserts.sv
// port assertions for the configuration bank
`timescale 1ns/1ps
module prcb_bank_asserts #(
    parameter int NUM_RES = 5
) (
    input wire logic                 clk,
    input wire logic                 arst_n,
    input wire logic                 scl,
    input wire logic                 sda_in,
    input wire logic                 sda_out,
    input wire logic                 sda_oe_n,
    input wire logic [NUM_RES-1:0]   warm_enter,
    input wire logic [NUM_RES*4-1:0] present_state,
    input wire logic [1:0]           sys_cond,
    input wire logic [NUM_RES*3-1:0] group_membership,
    input wire logic [NUM_RES*2-1:0] secondary_class,
    input wire logic [NUM_RES*3-1:0] primary_class,
    input wire logic [NUM_RES*4-1:0] target_state,
    input wire logic [NUM_RES-1:0]   vsel_restore
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_vsel_pulse: assert property (vsel_restore == $past(warm_enter))
        else $error("restore pulse does not follow warm entry");
    a_warm_group: assert property (warm_enter[1] |=>
        group_membership[5:3] == 3'h7 || $stable(group_membership[5:3]))
        else $error("warm entry left an odd group");
    a_reset_vals: assert property ($rose(arst_n) |-> group_membership == '1
        && secondary_class == '0 && primary_class == {3'h0, 3'h0, 3'h6, 3'h3, 3'h0})
        else $error("configuration outputs wrong after reset");
    // writes land only while the device acks, so a quiet bus means frozen fields
    a_cfg_quiet: assert property (warm_enter == '0 && sda_oe_n && $past(sda_oe_n) |=>
        $stable({group_membership, secondary_class, primary_class}))
        else $error("configuration moved without a cause");
    a_active_follow: assert property (sys_cond == 2'h0 ##1 sys_cond == 2'h0 |->
        target_state == $past(present_state))
        else $error("target does not follow present state");
    a_remap_hold: assert property (sys_cond != 2'h0 && $stable(sys_cond) && sda_oe_n
        && $past(sda_oe_n) |=> $stable(target_state))
        else $error("remapped target moved");
    a_sda_low: assert property (sda_out == 1'b0)
        else $error("data pin drive value not low");
    a_ack_in_low: assert property ($fell(sda_oe_n) |-> !scl)
        else $error("data pin pulled while clock high");
    c_warm: cover property (warm_enter[2]);
    c_off: cover property (sys_cond == 2'h2);
    c_ack: cover property ($fell(sda_oe_n));
endmodule : prcb_bank_asserts

bind prcb_bank prcb_bank_asserts #(.NUM_RES(NUM_RES)) u_prcb_bank_asserts (.clk(clk),
    .arst_n(arst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .warm_enter(warm_enter), .present_state(present_state), .sys_cond(sys_cond),
    .group_membership(group_membership), .secondary_class(secondary_class),
    .primary_class(primary_class), .target_state(target_state), .vsel_restore(vsel_restore));

//--- tb/test_prcb_bank.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
module test_prcb_bank;
    logic        clk, arst_n, scl, sda_m, sda_out, sda_oe_n;
    logic [4:0]  warm_enter, vsel_restore;
    logic [19:0] present_state, target_state;
    logic [1:0]  sys_cond;
    logic [14:0] group_membership, primary_class;
    logic [9:0]  secondary_class;
    logic [7:0]  q;
    logic        ak;
    int          mismatches, n_compared;
    // open-drain wire: either side may pull low
    wire logic   sda_in = sda_m & (sda_oe_n | sda_out);

    prcb_bank u_prcb_bank (.clk(clk), .arst_n(arst_n), .scl(scl), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .warm_enter(warm_enter),
        .present_state(present_state), .sys_cond(sys_cond),
        .group_membership(group_membership), .secondary_class(secondary_class),
        .primary_class(primary_class), .target_state(target_state),
        .vsel_restore(vsel_restore));

    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w
    task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // low phases of 8 clocks and high phases of 9 leave room for the three-flop pin filters
    task automatic bit_io(input logic b, output logic r);
        w(1);
        scl <= 1'b0;
        w(3);
        sda_m <= b;
        w(5);
        scl <= 1'b1;
        w(8);
        r = sda_in;
    endtask : bit_io
    task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] r,
        output logic a);
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(ai, a);
    endtask : xfer
    task automatic edge_c(input logic first);
        w(1);
        scl <= 1'b0;
        w(3);
        sda_m <= first;
        w(5);
        scl <= 1'b1;
        w(5);
        sda_m <= !first;
        w(8);
    endtask : edge_c
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        edge_c(1'b1);
        xfer({prcb_pkg::PRCB_DEVICE_ADDR, 1'b0}, 1'b1, q, ak);
        xfer(a, 1'b1, q, ak);
        xfer(d, 1'b1, q, ak);
        chk(ak, 0, "write ack");
        edge_c(1'b0);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        edge_c(1'b1);
        xfer({prcb_pkg::PRCB_DEVICE_ADDR, 1'b0}, 1'b1, q, ak);
        xfer(a, 1'b1, q, ak);
        edge_c(1'b1);
        xfer({prcb_pkg::PRCB_DEVICE_ADDR, 1'b1}, 1'b1, q, ak);
        xfer(8'hff, 1'b1, q, ak);
        chk(q, exp, "register read");
        edge_c(1'b0);
    endtask : rdc
    task automatic pulse(input int k);
        warm_enter[k] <= 1'b1;
        @(posedge clk);
        warm_enter <= '0;
        #1;
        chk(vsel_restore, 5'h1 << k, "restore pulse");
    endtask : pulse

    task automatic t_reset_map;
        logic [14:0] pri;
        pri = {3'h0, 3'h0, 3'h6, 3'h3, 3'h0};
        for (int k = 0; k < 5; k++) begin
            rdc(8'(8'hdd + 3 * k), 8'he0);
            rdc(8'(8'hde + 3 * k), {5'h0, pri[3 * k +: 3]});
            rdc(8'(8'hdf + 3 * k), 8'h08);
        end
        rdc(8'hdc, 8'h00);
        edge_c(1'b1);
        xfer(8'h98, 1'b1, q, ak);
        chk(ak, 1, "foreign address ack");
        edge_c(1'b0);
    endtask : t_reset_map
    task automatic t_fields;
        wr(8'he1, 8'hff);
        rdc(8'he1, 8'h1f);
        chk({secondary_class[3:2], primary_class[5:3]}, 5'h1f, "class outputs");
        wr(8'he0, 8'h5f);
        chk(group_membership[5:3], 3'h2, "group output");
        rdc(8'he0, 8'h50);
        present_state[7:4] <= 4'ha;
        rdc(8'he0, 8'h5a);
    endtask : t_fields
    task automatic t_warm;
        pulse(1);
        chk(group_membership[5:3], 3'h7, "forced group");
        wr(8'he3, 8'h20);
        pulse(2);
        chk(group_membership[8:6], 3'h1, "kept group");
    endtask : t_warm
    task automatic t_remap;
        wr(8'he8, 8'h5c);
        present_state[15:12] <= 4'h3;
        w(3);
        chk(target_state[15:12], 4'h3, "active target");
        sys_cond <= prcb_pkg::PRCB_COND_SLEEP;
        w(3);
        chk({target_state[15:12], target_state[3:0]}, 8'hc8, "sleep target");
        sys_cond <= prcb_pkg::PRCB_COND_OFF;
        w(3);
        chk(target_state[15:12], 4'h5, "off target");
        wr(8'he8, 8'h9e);
        w(3);
        chk(target_state[15:12], 4'h9, "rewritten off target");
        sys_cond <= prcb_pkg::PRCB_COND_ACTIVE;
        w(3);
        chk(target_state, present_state, "back to active");
        // the unused condition code must behave as active
        sys_cond <= 2'h3;
        present_state[15:12] <= 4'h6;
        w(3);
        chk(target_state, present_state, "unused condition");
        sys_cond <= prcb_pkg::PRCB_COND_ACTIVE;
    endtask : t_remap

    task automatic report_and_stop;
        $display("mismatches %0d of %0d compared", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        w(80000);
        mismatches++;
        report_and_stop;
    end
    initial begin
        {arst_n, warm_enter, present_state, sys_cond} = '0;
        {scl, sda_m} = 2'b11;
        w(3);
        arst_n <= 1'b1;
        w(6);
        t_reset_map;
        t_fields;
        t_warm;
        t_remap;
        report_and_stop;
    end
endmodule : test_prcb_bank
